// [rtl/ifc_defines.vh]
/*
  Constants of the interrupt flag, edge select and supply monitor block:
  register indices, field positions, write masks and timing counts.
  Assumes a single 250 MHz clock and a byte wide special register port.
*/
`ifndef IFC_DEFINES_VH
`define IFC_DEFINES_VH

// ----------------------------------------------------------------
// Register indices on the special register port
// ----------------------------------------------------------------
`define IFC_IDX_LVD_CONTROL 4'h0
`define IFC_IDX_EDGE_SELECT 4'h1
`define IFC_IDX_PRIMARY_0 4'h2
`define IFC_IDX_PRIMARY_1 4'h3
`define IFC_IDX_PRIMARY_2 4'h4
`define IFC_IDX_PRIMARY_3 4'h5
`define IFC_IDX_MULTI_0 4'h6
`define IFC_IDX_MULTI_3 4'h9
`define IFC_IDX_MULTI_9 4'hf

// ----------------------------------------------------------------
// Reset values and implemented bit masks
// ----------------------------------------------------------------
`define IFC_RESET_VALUE 8'h00
`define IFC_MASK_FULL 8'hff
`define IFC_MASK_LVD_CONTROL 8'h17
`define IFC_MASK_PRIMARY_0 8'h7f
`define IFC_MASK_MULTI_2 8'h33
`define IFC_MASK_MULTI_HIGH 8'h77

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IFC_LVD_OUT_BIT 5
`define IFC_LVD_EN_BIT 4
`define IFC_LVD_CODE_MSB 2
`define IFC_GLOBAL_EN_BIT 0
`define IFC_LV_FLAG_BIT 4

// ----------------------------------------------------------------
// Edge select codes
// ----------------------------------------------------------------
`define IFC_EDGE_OFF 2'h0
`define IFC_EDGE_RISE 2'h1
`define IFC_EDGE_FALL 2'h2
`define IFC_EDGE_BOTH 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IFC_CLK_MHZ 250
`define IFC_LVD_IRQ_DELAY_NS 120
`define IFC_LVD_IRQ_DELAY_CYC ((`IFC_LVD_IRQ_DELAY_NS * `IFC_CLK_MHZ + 999) / 1000)

`endif

// [rtl/ifc_irq_ctrl.v]
/*
  Interrupt request and enable register bank with external pin edge
  select and the digital side of the supply monitor.
  Assumes a byte wide special register port on ref_clk, event pulses from
  peripherals on ref_clk, and asynchronous pins and comparator output.
*/
// How it works
// - Per pin code 00 off, 01 rising, 10 falling, 11 both edges.
// - Edge select holds pin3..pin0 fields high to low, reset zero.
// - Each source has hardware set flag and software enable bit.
// - Primary 0: group6 flag, pin1, pin0 flags, their enables, global enable.
// - Primary 1: converter, group 1, 0, 7 flags over matching enables.
// - Primary 2: group 3, 9, 8, 2 flags over matching enables.
// - Primary 3: group 5, 4, pin3, pin2 flags over matching enables.
// - Groups 0, 1, 4 hold two timers' flags; group 2 one timer.
// - Group 3 holds serial, SPI, EEPROM, low supply flags; low supply bit 4.
// - Groups 5 to 9 use flags 6..4 and enables 2..0.
// - Three bit threshold code in control bits 2..0.
// - Control bit 4 enables the supply monitor.
// - Bit 5 read only monitor output; bits 7, 6, 3 read zero.
// - Sleep turns the monitor off whatever its enable.
// - Low supply flag sets a fixed delay after output goes high.
// - Low supply interrupt wakes from idle unless flag already set.
// - Output may chatter near threshold; delay restarts on each drop.
// - Flag one means pending; enable one means enabled.
// - All primary register bits reset to zero.
`timescale 1ns/100ps
`default_nettype none
`include "ifc_defines.vh"

module ifc_irq_ctrl #(
  parameter integer LVD_IRQ_DELAY_CYC = `IFC_LVD_IRQ_DELAY_CYC
) (
  input wire ref_clk,
  input wire reset,
  input wire [3:0] sfr_addr,
  input wire sfr_write,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire [3:0] external_irq_pins,
  input wire converter_event,
  input wire [39:0] group_events,
  input wire low_supply_raw,
  input wire sleep_mode,
  input wire idle_mode,
  output reg irq_pending,
  output reg monitor_power_on,
  output reg [2:0] supply_threshold_code,
  output reg idle_wake
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] regs [0:15];
  reg [3:0] pin_sync1;
  reg [3:0] pin_sync2;
  reg [3:0] pin_prev;
  reg lvd_sync1;
  reg lvd_sync2;
  reg [31:0] lvd_count;
  reg lvd_fired;
  wire [3:0] pin_hit;
  wire [9:0] group_pending;
  wire [7:0] ext_edge_select;
  wire monitor_active;
  wire low_supply_output_flag;
  wire lvd_set;
  wire [7:0] set_bits [0:15];
  wire [7:0] masks [0:15];

  assign ext_edge_select = regs[`IFC_IDX_EDGE_SELECT];
  assign monitor_active = regs[`IFC_IDX_LVD_CONTROL][`IFC_LVD_EN_BIT] & ~sleep_mode;
  assign low_supply_output_flag = monitor_active & lvd_sync2;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_sync1 <= 4'h0;
      pin_sync2 <= 4'h0;
      pin_prev <= 4'h0;
      lvd_sync1 <= 1'b0;
      lvd_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= external_irq_pins;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
      lvd_sync1 <= low_supply_raw;
      lvd_sync2 <= lvd_sync1;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_pin
      wire [1:0] pin_edge_select = ext_edge_select[2*p+1:2*p];
      wire rise = pin_sync2[p] & ~pin_prev[p];
      wire fall = ~pin_sync2[p] & pin_prev[p];
      assign pin_hit[p] = (pin_edge_select == `IFC_EDGE_RISE) ? rise :
                          (pin_edge_select == `IFC_EDGE_FALL) ? fall :
                          (pin_edge_select == `IFC_EDGE_BOTH) ? (rise | fall) :
                          1'b0;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Supply monitor interrupt delay
  // ----------------------------------------------------------------
  assign lvd_set = low_supply_output_flag & ~lvd_fired &
                   (lvd_count >= LVD_IRQ_DELAY_CYC - 1);

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lvd_count <= 32'h0;
      lvd_fired <= 1'b0;
    end else if (!low_supply_output_flag) begin
      lvd_count <= 32'h0;
      lvd_fired <= 1'b0;
    end else begin
      if (lvd_count < LVD_IRQ_DELAY_CYC - 1) begin
        lvd_count <= lvd_count + 32'h1;
      end
      if (lvd_set) begin
        lvd_fired <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware set sources per register
  // ----------------------------------------------------------------
  genvar m;
  generate
    for (m = 0; m < 10; m = m + 1) begin : g_group
      wire [7:0] cur = regs[`IFC_IDX_MULTI_0 + m];
      assign group_pending[m] = |(cur[7:4] & cur[3:0]);
      if (m == 3) begin : g_lv
        assign set_bits[`IFC_IDX_MULTI_0 + m] =
          {group_events[4*m+3:4*m+1], lvd_set, 4'h0};
      end else begin : g_plain
        assign set_bits[`IFC_IDX_MULTI_0 + m] = {group_events[4*m+3:4*m], 4'h0};
      end
      assign masks[`IFC_IDX_MULTI_0 + m] = (m == 2) ? `IFC_MASK_MULTI_2 :
                                           (m >= 5) ? `IFC_MASK_MULTI_HIGH :
                                           `IFC_MASK_FULL;
    end
  endgenerate

  assign set_bits[`IFC_IDX_LVD_CONTROL] = 8'h00;
  assign set_bits[`IFC_IDX_EDGE_SELECT] = 8'h00;
  assign set_bits[`IFC_IDX_PRIMARY_0] =
    {1'b0, group_pending[6], pin_hit[1], pin_hit[0], 4'h0};
  assign set_bits[`IFC_IDX_PRIMARY_1] =
    {converter_event, group_pending[1], group_pending[0], group_pending[7], 4'h0};
  assign set_bits[`IFC_IDX_PRIMARY_2] =
    {group_pending[3], group_pending[9], group_pending[8], group_pending[2], 4'h0};
  assign set_bits[`IFC_IDX_PRIMARY_3] =
    {group_pending[5], group_pending[4], pin_hit[3], pin_hit[2], 4'h0};
  assign masks[`IFC_IDX_LVD_CONTROL] = `IFC_MASK_LVD_CONTROL;
  assign masks[`IFC_IDX_EDGE_SELECT] = `IFC_MASK_FULL;
  assign masks[`IFC_IDX_PRIMARY_0] = `IFC_MASK_PRIMARY_0;
  assign masks[`IFC_IDX_PRIMARY_1] = `IFC_MASK_FULL;
  assign masks[`IFC_IDX_PRIMARY_2] = `IFC_MASK_FULL;
  assign masks[`IFC_IDX_PRIMARY_3] = `IFC_MASK_FULL;

  // ----------------------------------------------------------------
  // Register bank: hardware set wins over a software write
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < 16; r = r + 1) begin : g_reg
      localparam [3:0] REG_IDX = r;
      wire hit = sfr_write & (sfr_addr == REG_IDX);
      wire [7:0] next_value = ((hit ? sfr_wdata : regs[r]) | set_bits[r]) & masks[r];
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          regs[r] <= `IFC_RESET_VALUE;
        end else begin
          regs[r] <= next_value;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs and read data
  // ----------------------------------------------------------------
  wire [7:0] p0 = regs[`IFC_IDX_PRIMARY_0];
  wire [7:0] p1 = regs[`IFC_IDX_PRIMARY_1];
  wire [7:0] p2 = regs[`IFC_IDX_PRIMARY_2];
  wire [7:0] p3 = regs[`IFC_IDX_PRIMARY_3];
  wire next_irq_pending = p0[`IFC_GLOBAL_EN_BIT] &
    (|(p0[6:4] & p0[3:1]) | |(p1[7:4] & p1[3:0]) |
     |(p2[7:4] & p2[3:0]) | |(p3[7:4] & p3[3:0]));
  wire [7:0] next_rdata = (sfr_addr == `IFC_IDX_LVD_CONTROL) ?
    (regs[sfr_addr] | {2'b00, low_supply_output_flag, 5'h00}) : regs[sfr_addr];

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
      irq_pending <= 1'b0;
      monitor_power_on <= 1'b0;
      supply_threshold_code <= 3'h0;
      idle_wake <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      irq_pending <= next_irq_pending;
      monitor_power_on <= monitor_active;
      supply_threshold_code <= regs[`IFC_IDX_LVD_CONTROL][`IFC_LVD_CODE_MSB:0];
      idle_wake <= idle_mode & lvd_set &
                   ~regs[`IFC_IDX_MULTI_3][`IFC_LV_FLAG_BIT];
    end
  end

endmodule // ifc_irq_ctrl
`default_nettype wire

// [tb/ifc_irq_props.sv]
/* Port checker for the interrupt flag and supply monitor block.
   Bound to ifc_irq_ctrl; one clock domain, reset active high. */
`timescale 1ns/100ps
`default_nettype none
module ifc_irq_props #(
  parameter integer LVD_IRQ_DELAY_CYC = 30
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic low_supply_raw,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic irq_pending,
  input wire logic monitor_power_on,
  input wire logic [2:0] supply_threshold_code,
  input wire logic idle_wake
);
  int low_run;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) low_run <= 0;
    else low_run <= (low_supply_raw && monitor_power_on) ? low_run + 1 : 0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sleep_off; sleep_mode |=> !monitor_power_on; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("monitor on in sleep");
  property p_power; sfr_write && sfr_addr == 4'h0 ##1 !sleep_mode
    |=> monitor_power_on == $past(sfr_wdata[4], 2); endproperty
  a_power: assert property (p_power) else $error("monitor power wrong");
  property p_code; sfr_write && sfr_addr == 4'h0
    |=> ##1 supply_threshold_code == $past(sfr_wdata[2:0], 2); endproperty
  a_code: assert property (p_code) else $error("threshold code wrong");
  property p_ctl_zero; sfr_addr == 4'h0 |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3]; endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("control gap bits set");
  property p_p0_top; sfr_addr == 4'h2 |=> !sfr_rdata[7]; endproperty
  a_p0_top: assert property (p_p0_top) else $error("primary 0 bit 7 set");
  property p_m2_gap; sfr_addr == 4'h8 |=> (sfr_rdata & 8'hcc) == 8'h00; endproperty
  a_m2_gap: assert property (p_m2_gap) else $error("group 2 gap bits set");
  property p_m5_gap; sfr_addr >= 4'hb |=> (sfr_rdata & 8'h88) == 8'h00; endproperty
  a_m5_gap: assert property (p_m5_gap) else $error("group gap bits set");
  property p_gl_off; sfr_write && sfr_addr == 4'h2 && !sfr_wdata[0] |=> ##1 !irq_pending;
  endproperty
  a_gl_off: assert property (p_gl_off) else $error("request without global");
  property p_wake_idle; idle_wake |-> $past(idle_mode) ##1 !idle_wake; endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("bad idle wake");
  property p_wake_dly; idle_wake |-> low_run >= LVD_IRQ_DELAY_CYC; endproperty
  a_wake_dly: assert property (p_wake_dly) else $error("low flag too early");
  c_wake: cover property (idle_wake);
  c_pend: cover property ($rose(irq_pending));
  c_power: cover property ($rose(monitor_power_on));
endmodule // ifc_irq_props
bind ifc_irq_ctrl ifc_irq_props #(.LVD_IRQ_DELAY_CYC(LVD_IRQ_DELAY_CYC)) u_ifc_irq_props (
  .ref_clk, .reset, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata, .low_supply_raw,
  .sleep_mode, .idle_mode, .irq_pending, .monitor_power_on, .supply_threshold_code, .idle_wake);
`default_nettype wire

// [tb/ifc_src_model.sv]
/* Event sources, external pins and supply comparator of the block.
   Changes its outputs just after falling edges of ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module ifc_src_model (
  input wire logic ref_clk,
  output var logic [3:0] external_irq_pins = 4'h0,
  output var logic converter_event = 1'b0,
  output var logic [39:0] group_events = 40'h0,
  output var logic low_supply_raw = 1'b0
);
  // One clock wide event pulse, negative index is the converter
  task automatic fire(input int idx);
    @(negedge ref_clk);
    if (idx < 0) converter_event = 1'b1;
    else group_events[idx] = 1'b1;
    @(negedge ref_clk);
    converter_event = 1'b0;
    group_events = 40'h0;
  endtask
  task automatic pin(input int n, input logic v);
    @(negedge ref_clk);
    external_irq_pins[n] = v;
  endtask
  task automatic supply_low(input logic v);
    @(negedge ref_clk);
    low_supply_raw = v;
  endtask
endmodule // ifc_src_model
`default_nettype wire

// [tb/test_irq_flags_edge_lvd_ctrl.sv]
/* Self-checking bench for the interrupt flag block.
   Drives inputs at falling edges; sources come from ifc_src_model. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_irq_flags_edge_lvd_ctrl;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] sfr_addr = 4'h0;
  logic sfr_write = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  wire logic [7:0] sfr_rdata;
  wire logic [3:0] external_irq_pins;
  wire logic [39:0] group_events;
  wire logic [2:0] supply_threshold_code;
  wire logic converter_event, low_supply_raw, irq_pending, monitor_power_on, idle_wake;
  int mismatches = 0;
  int check_count = 0;
  always #2 ref_clk = ~ref_clk;
  ifc_src_model u_ifc_src_model (.ref_clk, .external_irq_pins, .converter_event,
    .group_events, .low_supply_raw);
  ifc_irq_ctrl #(.LVD_IRQ_DELAY_CYC(4)) u_ifc_irq_ctrl (.ref_clk, .reset, .sfr_addr,
    .sfr_write, .sfr_wdata, .sfr_rdata, .external_irq_pins, .converter_event, .group_events,
    .low_supply_raw, .sleep_mode, .idle_mode, .irq_pending, .monitor_power_on,
    .supply_threshold_code, .idle_wake);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_write = 1'b1;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_write = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    `CHK(sfr_rdata, e)
  endtask
  task automatic pend(input logic e);
    @(negedge ref_clk);
    `CHK(irq_pending, e)
  endtask
  task automatic t_masks;
    logic [3:0] ad[5] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'hb};
    logic [7:0] mk[5] = '{8'h17, 8'h7f, 8'hff, 8'h33, 8'h77};
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], 8'hff);
      rd(ad[i], mk[i]);
      wr(ad[i], 8'h00);
    end
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h2, 8'h13);
    pend(1'b1);
    wr(4'h2, 8'h12);
    pend(1'b0);
    wr(4'h2, 8'h11);
    pend(1'b0);
  endtask
  task automatic t_edges;
    logic [3:0] fa;
    logic [7:0] fb;
    for (int n = 0; n < 4; n++)
      for (int c = 0; c < 4; c++) begin
        fa = (n < 2) ? 4'h2 : 4'h5;
        fb = 8'h10 << (n % 2);
        wr(4'h1, 8'(c << (2 * n)));
        wr(fa, 8'h00);
        u_ifc_src_model.pin(n, 1'b1);
        repeat (6) @(negedge ref_clk);
        rd(fa, c[0] ? fb : 8'h00);
        wr(fa, 8'h00);
        u_ifc_src_model.pin(n, 1'b0);
        repeat (6) @(negedge ref_clk);
        rd(fa, c[1] ? fb : 8'h00);
      end
  endtask
  task automatic t_groups;
    for (int g = 0; g < 10; g++)
      for (int k = 0; k < 4; k++)
        if (!(g == 3 && k == 0) && !(g == 2 && k > 1) && !(g > 4 && k == 3)) begin
          u_ifc_src_model.fire(4 * g + k);
          rd(4'(6 + g), 8'h10 << k);
          wr(4'(6 + g), 8'h00);
        end
    wr(4'h6, 8'h01);
    wr(4'h3, 8'h02);
    wr(4'h2, 8'h01);
    u_ifc_src_model.fire(0);
    u_ifc_src_model.fire(4);
    u_ifc_src_model.fire(-1);
    repeat (3) @(negedge ref_clk);
    rd(4'h6, 8'h11);
    rd(4'h3, 8'ha2);
    pend(1'b1);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h3, 8'h00);
  endtask
  task automatic t_monitor;
    int k;
    idle_mode = 1'b1;
    wr(4'h0, 8'h15);
    repeat (8) @(negedge ref_clk);
    `CHK(supply_threshold_code, 3'h5)
    u_ifc_src_model.supply_low(1'b1);
    u_ifc_src_model.supply_low(1'b0);
    rd(4'h9, 8'h00);
    u_ifc_src_model.supply_low(1'b1);
    k = 0;
    while (idle_wake !== 1'b1 && k < 40) begin @(posedge ref_clk); #1; k++; end
    `CHK(idle_wake, 1'b1)
    rd(4'h9, 8'h10);
    rd(4'h0, 8'h35);
    u_ifc_src_model.supply_low(1'b0);
    u_ifc_src_model.supply_low(1'b1);
    k = 0;
    repeat (20) begin @(posedge ref_clk); #1; if (idle_wake === 1'b1) k++; end
    `CHK(k, 0)
    @(negedge ref_clk);
    sleep_mode = 1'b1;
    rd(4'h0, 8'h15);
    `CHK(monitor_power_on, 1'b0)
    sleep_mode = 1'b0;
    idle_mode = 1'b0;
    u_ifc_src_model.supply_low(1'b0);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    t_masks;
    t_edges;
    t_groups;
    t_monitor;
    give_verdict;
  end
endmodule // test_irq_flags_edge_lvd_ctrl
`default_nettype wire
